// file: design/swe_eeprom_port.sv
// Serial command port of a 16-bit word nonvolatile memory
//
// Contract
// - Array holds 16-bit words, 128 or 256 of them.
// - Each write stores exactly one whole word.
// - Command, address and data bits are taken on shift clock rises.
// - Read data on serial out changes only on shift clock falls; status output changes when busy ends.
// - Write guard affects write commands only.
// - Write guard high inhibits all writes.
// - Busy shows on ready/busy pin and on request on serial out.
// - Write enable latch is cleared at reset.
// - Addressed word is erased automatically before programming.
// - Frame is 1010, opcode, address; 8/4/3/0 select read/write/unlock/lock.
// - Writes stay enabled until the lock command.
// - Ready/busy drops after the 32nd rise and stays low while programming.
// - Read shifts 16 bits out from the 16th fall, one per fall.
`timescale 1ns/100ps
module swe_eeprom_port
    import swe_pkg::*;
#(
    parameter int WORDS       = swe_pkg::WORDS,
    parameter int PROG_CYCLES = swe_pkg::PROG_CYCLES
) (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RST,
    // Serial link pins
    input  wire logic SELECT_N,
    input  wire logic SERIAL_SHIFT_CLOCK,
    input  wire logic SERIAL_IN_LINE,
    input  wire logic WRITE_GUARD,
    output logic      SERIAL_OUT,
    output logic      SERIAL_OUT_OE_N,
    // Status pin
    output logic      READY_BUSY
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [3:0]        sync_a;
    logic [3:0]        sync_b;
    logic              sk_d;
    logic              sel_d;
    swe_state_t        state;
    logic [5:0]        cnt;
    logic [7:0]        head;
    logic [DATA_W-1:0] field;
    logic [ADDR_W-1:0] addr;
    logic              unlock;
    logic [TIMER_W-1:0] timer;
    logic [DATA_W-1:0] out_sr;
    logic [4:0]        out_cnt;
    logic              out_bit;
    logic              status_mode;
    logic              status_show;

    swe_mem_if mem_bus ();

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: first rank feeds only the second rank
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            // Idle pin levels: deselected, clock low, guard raised
            sync_a <= 4'h9;
            sync_b <= 4'h9;
        end else begin
            sync_a <= {SELECT_N, SERIAL_SHIFT_CLOCK, SERIAL_IN_LINE,
                       WRITE_GUARD};
            sync_b <= sync_a;
        end
    end

    // Edge history of the synchronised pins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sk_d  <= 1'b0;                               // No false fall
            sel_d <= 1'b0;
        end else begin
            sk_d  <= sync_b[2];
            sel_d <= ~sync_b[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded pin events
    wire sel       = ~sync_b[3];
    wire sk        = sync_b[2];
    wire din       = sync_b[1];
    wire guard     = sync_b[0];
    wire sk_rise   = sk & ~sk_d;
    wire sk_fall   = ~sk & sk_d;
    wire sel_fall  = sel & ~sel_d;
    wire busy      = (state == ST_PROG);
    wire [7:0] head_nx   = {head[6:0], din};
    wire [DATA_W-1:0] field_nx = {din, field[DATA_W-1:1]};
    wire head_ok   = (head_nx[7:4] == START_CODE);
    wire [3:0] op  = head[3:0];
    wire prog_end  = (timer == TIMER_W'(PROG_CYCLES - 1));
    // Guard low is needed at the last data bit of a write and all through programming
    wire write_ok  = unlock & ~guard;

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer; deselect ends any frame, but not programming
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state   <= ST_IDLE;
            cnt     <= CNT_RESET;
            head    <= 8'h00;
            field   <= '0;
            addr    <= '0;
            unlock  <= UNLOCK_RESET;
            timer   <= '0;
        end else if (state != ST_PROG && !sel) begin
            state   <= ST_IDLE;
            cnt     <= CNT_RESET;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    state <= ST_HEAD;
                end
                ST_HEAD: if (sk_rise) begin
                    head <= head_nx;
                    cnt  <= cnt + 6'h01;
                    if (cnt == CNT_HEAD_END) begin
                        state <= head_ok ? ST_ADDR : ST_DONE;
                    end
                end
                ST_ADDR: if (sk_rise) begin
                    field <= field_nx;
                    cnt   <= cnt + 6'h01;
                    if (cnt == CNT_ADDR_END) begin
                        addr <= field_nx[DATA_W-1 -: ADDR_W];
                        unique case (op)
                            OP_READ:   state <= ST_READ;
                            OP_WRITE:  state <= ST_DATA;
                            OP_UNLOCK: begin
                                unlock <= 1'b1;
                                state  <= ST_DONE;
                            end
                            OP_LOCK: begin
                                unlock <= 1'b0;
                                state  <= ST_DONE;
                            end
                            default:   state <= ST_DONE;
                        endcase
                    end
                end
                ST_DATA: if (sk_rise) begin
                    field <= field_nx;
                    cnt   <= cnt + 6'h01;
                    if (cnt == CNT_DATA_END) begin
                        timer <= '0;
                        state <= write_ok ? ST_PROG : ST_DONE;
                    end
                end
                ST_READ: begin
                    if (out_cnt == READ_BITS) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_DONE;  // Wait for deselect
                end
                ST_PROG: begin
                    // Guard raised mid-write abandons the word unwritten
                    timer <= timer + TIMER_W'(1);
                    if (guard || prog_end) begin
                        state <= ST_DONE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory requests: read fetch at end of address, commit at end of time
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mem_bus.rd_en   <= 1'b0;
            mem_bus.wr_en   <= 1'b0;
            mem_bus.rd_addr <= '0;
            mem_bus.wr_addr <= '0;
            mem_bus.wr_data <= '0;
        end else begin
            mem_bus.rd_en   <= (state == ST_READ) && (out_cnt == 5'h00);
            mem_bus.rd_addr <= addr;
            mem_bus.wr_en   <= busy && prog_end && !guard;
            mem_bus.wr_addr <= addr;
            mem_bus.wr_data <= field;
        end
    end

    swe_mem #(
        .WORDS (WORDS)
    ) u_mem (
        .clk (CLK),
        .mem (mem_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read shifter: word loads on the first fall, then one bit per fall
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            out_sr  <= '0;
            out_cnt <= 5'h00;
            out_bit <= 1'b0;
        end else if (state != ST_READ) begin
            // Last bit stands until deselect, so it never moves off a fall
            out_cnt <= 5'h00;
            if (!sel) begin
                out_bit <= 1'b0;
            end
        end else if (sk_fall && out_cnt != READ_BITS) begin
            out_cnt <= out_cnt + 5'h01;
            if (out_cnt == 5'h00) begin
                out_bit <= mem_bus.rd_data[0];
                out_sr  <= mem_bus.rd_data >> 1;
            end else begin
                out_bit <= out_sr[0];
                out_sr  <= out_sr >> 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status request: armed by a write, shown when select falls with SK low
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            status_mode <= 1'b0;
            status_show <= 1'b0;
        end else begin
            if (state == ST_DATA && sk_rise && cnt == CNT_DATA_END) begin
                status_mode <= write_ok;
            end else if (!sel && !busy) begin
                status_mode <= 1'b0;
            end
            if (sel_fall && !sk && status_mode) begin
                status_show <= 1'b1;
            end else if (!sel) begin
                status_show <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered pins; output released whenever select is high
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SERIAL_OUT      <= 1'b0;
            SERIAL_OUT_OE_N <= 1'b1;
            READY_BUSY      <= 1'b1;
        end else begin
            SERIAL_OUT      <= status_show ? ~busy : out_bit;
            SERIAL_OUT_OE_N <= ~sel;
            READY_BUSY      <= ~busy;
        end
    end

endmodule : swe_eeprom_port

// file: design/swe_pkg.sv
// Constants and types shared by the serial word memory port
package swe_pkg;
    // Array organisation
    localparam int WORDS      = 256;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 16;

    // Bit counts at which each command field ends
    localparam logic [5:0] CNT_HEAD_END = 6'h07;
    localparam logic [5:0] CNT_ADDR_END = 6'h0f;
    localparam logic [5:0] CNT_DATA_END = 6'h1f;
    localparam logic [4:0] READ_BITS    = 5'h10;

    // Start pattern and opcodes
    localparam logic [3:0] START_CODE = 4'ha;
    localparam logic [3:0] OP_READ    = 4'h8;
    localparam logic [3:0] OP_WRITE   = 4'h4;
    localparam logic [3:0] OP_UNLOCK  = 4'h3;
    localparam logic [3:0] OP_LOCK    = 4'h0;

    // Timing
    localparam int CLK_HZ           = 25_000_000;
    localparam int PROG_TIME_MS     = 10;
    localparam int PROG_CYCLES      = CLK_HZ / 1000 * PROG_TIME_MS;
    localparam int SELECT_GAP_NS    = 1000;
    localparam int TIMER_W          = 24;

    // Values after reset
    localparam logic       UNLOCK_RESET = 1'b0;
    localparam logic [5:0] CNT_RESET    = 6'h00;

    // Command sequencer states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_HEAD = 7'h02,
        ST_ADDR = 7'h04,
        ST_DATA = 7'h08,
        ST_READ = 7'h10,
        ST_DONE = 7'h20,
        ST_PROG = 7'h40
    } swe_state_t;
endpackage : swe_pkg

// file: design/swe_mem_if.sv
// Memory access signals between the port sequencer and the word array
`timescale 1ns/100ps
interface swe_mem_if;
    import swe_pkg::*;
    logic              rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;

    modport ctrl (output rd_en, rd_addr, wr_en, wr_addr, wr_data,
                  input rd_data);
    modport array (input rd_en, rd_addr, wr_en, wr_addr, wr_data,
                   output rd_data);
endinterface : swe_mem_if

// file: design/swe_mem.sv
// Word array with registered read data
`timescale 1ns/100ps
module swe_mem #(
    parameter int WORDS = swe_pkg::WORDS
) (
    // Clock
    input  wire logic  clk,
    // Access port
    swe_mem_if.array   mem
);
    import swe_pkg::*;

    logic [DATA_W-1:0] cells [WORDS];

    // Whole-word replace: old contents are gone in one step
    always_ff @(posedge clk) begin
        if (mem.wr_en) begin
            cells[mem.wr_addr] <= mem.wr_data;
        end
        if (mem.rd_en) begin
            mem.rd_data <= cells[mem.rd_addr];
        end
    end
endmodule : swe_mem

// file: verification/swe_host.sv
// Host model driving the serial link pins of the memory port
`timescale 1ns/100ps
module swe_host (
    // Clock
    input  wire logic clk,
    // Link pins
    output logic      sel_n,
    output logic      sck,
    output logic      sdi,
    input  wire logic sdo
);
    import swe_pkg::*;
    // Idle link: deselected, shift clock parked low
    initial begin
        sel_n = 1'b1;
        sck   = 1'b0;
        sdi   = 1'b0;
    end
    // Leave the frame; the data line toggles so no stale level survives
    task automatic end_frame();
        @(negedge clk);
        sel_n = 1'b1;
        sdi   = ~sdi;
        repeat (26) @(negedge clk);
    endtask : end_frame
    // Head MSB first, then address and data LSB first, 8 clocks a bit
    task automatic frame(input logic [3:0] op, input logic [7:0] a,
                         input logic [15:0] d, input int n,
                         output logic [15:0] q);
        logic [7:0] hd;
        hd    = {START_CODE, op};
        q     = 16'h0000;
        sel_n = 1'b0;
        repeat (2) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            sdi = (i < 8) ? hd[7-i] : (i < 16) ? a[i-8] : d[i-16];
            repeat (4) @(negedge clk);
            sck = 1'b1;
            repeat (4) @(negedge clk);
            if (i >= 16)
                q[i-16] = sdo; // Taken just before the next fall
            sck = 1'b0;
        end
        end_frame();
    endtask : frame
    // Status poll: select falls while the shift clock is low; one early
    // look, one after the short bench programming time has surely ended
    task automatic status(output logic s, output logic s_late);
        sel_n = 1'b0;
        repeat (6) @(negedge clk);
        s = sdo;
        repeat (40) @(negedge clk);
        s_late = sdo;
        end_frame();
    endtask : status
endmodule : swe_host

// file: verification/swe_eeprom_chk.sv
// Pin-level assertions for the serial memory port
`timescale 1ns/100ps
module swe_eeprom_chk #(
    parameter int PROG_CYCLES = swe_pkg::PROG_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Link pins
    input wire logic SELECT_N,
    input wire logic SERIAL_SHIFT_CLOCK,
    input wire logic SERIAL_IN_LINE,
    input wire logic WRITE_GUARD,
    input wire logic SERIAL_OUT,
    input wire logic SERIAL_OUT_OE_N,
    // Status pin
    input wire logic READY_BUSY
);
    logic [23:0] low_cnt;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Busy length, cleared whenever the part is ready
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            low_cnt <= 24'h000000;
        else if (READY_BUSY)
            low_cnt <= 24'h000000;
        else
            low_cnt <= low_cnt + 24'h000001;
    end
    chk_reset_idle: assert property (
        $fell(RST) |-> READY_BUSY && SERIAL_OUT_OE_N)
        else $error("Outputs not idle after reset");
    chk_out_released: assert property (
        SELECT_N [*4] |-> SERIAL_OUT_OE_N)
        else $error("Serial out driven while deselected");
    chk_out_on_fall: assert property (
        $changed(SERIAL_OUT) && !SERIAL_OUT_OE_N |->
        !$past(SERIAL_SHIFT_CLOCK, 2) && !$past(SERIAL_SHIFT_CLOCK, 3))
        else $error("Serial out moved away from a clock fall");
    chk_busy_len: assert property (
        $rose(READY_BUSY) |-> WRITE_GUARD ||
        (low_cnt >= PROG_CYCLES - 1 && low_cnt <= PROG_CYCLES + 1))
        else $error("Programming time wrong");
    chk_busy_hold: assert property (
        $fell(READY_BUSY) && !WRITE_GUARD |=> !READY_BUSY [*8])
        else $error("Busy dropped early");
    chk_guard_blocks: assert property (
        $fell(READY_BUSY) |-> !WRITE_GUARD && !$past(WRITE_GUARD, 3))
        else $error("Write started under guard");
    chk_busy_at_rise: assert property (
        $fell(READY_BUSY) |->
        $past(SERIAL_SHIFT_CLOCK, 4) || $past(SERIAL_SHIFT_CLOCK, 6))
        else $error("Busy not tied to a clock rise");
    chk_status_busy: assert property (
        !SERIAL_OUT_OE_N && !READY_BUSY && !$past(READY_BUSY, 2)
        |-> !SERIAL_OUT)
        else $error("Status not busy while programming");
    cov_busy: cover property ($fell(READY_BUSY));
    cov_done: cover property ($rose(READY_BUSY));
    cov_poll: cover property (!SERIAL_OUT_OE_N && !READY_BUSY);
endmodule : swe_eeprom_chk
bind swe_eeprom_port swe_eeprom_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_i (
    .CLK(CLK), .RST(RST), .SELECT_N(SELECT_N),
    .SERIAL_SHIFT_CLOCK(SERIAL_SHIFT_CLOCK),
    .SERIAL_IN_LINE(SERIAL_IN_LINE), .WRITE_GUARD(WRITE_GUARD),
    .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N),
    .READY_BUSY(READY_BUSY));

// file: verification/tb.sv
// Self-checking bench for the serial memory port
`timescale 1ns/100ps
module tb;
    import swe_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        guard = 1'b0;
    logic        sel_n, sck, sdi, sdo, sdo_oe_n, rdy, st, st_late;
    logic [15:0] q;
    wire         do_pin;
    int          miscompares = 0;
    int          checks_done = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    // Pull-up holds the released output line high
    assign do_pin = sdo_oe_n ? 1'b1 : sdo;
    // Short programming time keeps the run brief
    swe_eeprom_port #(.PROG_CYCLES(40)) swe_eeprom_port_i (
        .CLK(clk), .RST(rst), .SELECT_N(sel_n),
        .SERIAL_SHIFT_CLOCK(sck), .SERIAL_IN_LINE(sdi),
        .WRITE_GUARD(guard), .SERIAL_OUT(sdo),
        .SERIAL_OUT_OE_N(sdo_oe_n), .READY_BUSY(rdy));
    swe_host swe_host_i (.clk(clk), .sel_n(sel_n), .sck(sck),
        .sdi(sdi), .sdo(do_pin));
    task automatic cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t flag %b not %b", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t word %h not %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        swe_host_i.frame(OP_WRITE, a, d, 32, q);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        swe_host_i.frame(OP_READ, a, 16'h0000, 32, q);
    endtask : rd
    task automatic cmd(input logic [3:0] op);
        swe_host_i.frame(op, 8'h00, 16'h0000, 16, q);
    endtask : cmd
    // Bounded wait for programming to finish
    task automatic wait_ready();
        for (int n = 0; n < 200 && rdy !== 1'b1; n++) @(negedge clk);
        cmp_bit(rdy, 1'b1);
    endtask : wait_ready
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        cmp_bit(rdy, 1'b1);
        cmp_bit(sdo_oe_n, 1'b1);
        wr(8'h10, 16'hffff);
        cmp_bit(rdy, 1'b1);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_write();
        cmd(OP_UNLOCK);
        wr(8'hff, 16'h8001);
        cmp_bit(rdy, 1'b0);
        swe_host_i.status(st, st_late);
        cmp_bit(st, 1'b0);
        cmp_bit(st_late, 1'b1);
        wait_ready();
        rd(8'hff);
        cmp_word(q, 16'h8001);
        wr(8'hff, 16'ha55a);
        wait_ready();
        wr(8'h00, 16'h1234);
        wait_ready();
        rd(8'hff);
        cmp_word(q, 16'ha55a);
        rd(8'h00);
        cmp_word(q, 16'h1234);
        $display("t_write done");
    endtask : t_write
    // Guard blocks writes but not reads or the lock command
    task automatic t_guard();
        @(negedge clk) guard = 1'b1;
        wr(8'hff, 16'h0f0f);
        cmp_bit(rdy, 1'b1);
        rd(8'hff);
        cmp_word(q, 16'ha55a);
        cmd(OP_LOCK);
        @(negedge clk) guard = 1'b0;
        wr(8'hff, 16'h0f0f);
        cmp_bit(rdy, 1'b1);
        $display("t_guard done");
    endtask : t_guard
    // A frame begun during programming must be ignored
    task automatic t_refuse();
        cmd(OP_UNLOCK);
        wr(8'h00, 16'h1111);
        wr(8'h00, 16'h2222);
        cmp_bit(rdy, 1'b1);
        rd(8'h00);
        cmp_word(q, 16'h1111);
        // Guard raised mid-programming abandons the word and ends busy
        wr(8'h00, 16'h3333);
        guard = 1'b1;
        repeat (8) @(negedge clk);
        cmp_bit(rdy, 1'b1);
        guard = 1'b0;
        rd(8'h00);
        cmp_word(q, 16'h1111);
        $display("t_refuse done");
    endtask : t_refuse
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // Reset for 8 cycles, then the tests in turn
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_write();
        t_guard();
        t_refuse();
        end_of_test();
    end
    // About 20 frames of 300 cycles fit well inside this span
    initial begin
        #2000000;
        miscompares++;
        end_of_test();
    end
endmodule : tb
